// file: hw/pfc_pkg.sv
package pfc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int NFN = 3;
  localparam int NREG = 13;
  localparam int NRBAR = 5;
  localparam int PAGE_LSB = 12;
  // function 1 page base; functions 2 and 3 follow one page apart
  localparam logic [16:0] FN1_BASE = 17'h0_5000;
  localparam logic [16:0] FN3_BASE = 17'h0_7000;
  // byte offsets inside one function page
  localparam logic [11:0] OFS_MSI = 12'h0e8;
  localparam logic [11:0] OFS_MSIX = 12'h0f0;
  localparam logic [11:0] OFS_TBL = 12'h0f4;
  localparam logic [11:0] OFS_PBA = 12'h0f8;
  localparam logic [11:0] OFS_SN_EN = 12'h130;
  localparam logic [11:0] OFS_SN_LO = 12'h134;
  localparam logic [11:0] OFS_SN_HI = 12'h138;
  localparam logic [11:0] OFS_RB_EN = 12'h1a0;
  localparam logic [11:0] OFS_RB0 = 12'h1a4;
  localparam logic [11:0] OFS_RB1 = 12'h1a8;
  localparam logic [11:0] OFS_RB2 = 12'h1ac;
  localparam logic [11:0] OFS_RB3 = 12'h1b0;
  localparam logic [11:0] OFS_RB4 = 12'h1b4;
  // storage word index
  localparam logic [3:0] IDX_MSI = 4'h0;
  localparam logic [3:0] IDX_MSIX = 4'h1;
  localparam logic [3:0] IDX_TBL = 4'h2;
  localparam logic [3:0] IDX_PBA = 4'h3;
  localparam logic [3:0] IDX_SN_EN = 4'h4;
  localparam logic [3:0] IDX_SN_LO = 4'h5;
  localparam logic [3:0] IDX_SN_HI = 4'h6;
  localparam logic [3:0] IDX_RB_EN = 4'h7;
  localparam logic [3:0] IDX_RB0 = 4'h8;
  // field layout
  localparam int DIS_BIT = 0;
  localparam int EN_BIT = 0;
  localparam int MSI_MASK_BIT = 1;
  localparam int MSI_MULT_LSB = 4;
  localparam int MSI_MULT_W = 3;
  localparam logic [2:0] MSI_MULT_MAX = 3'h5;
  localparam logic [5:0] MSI_ONE_VEC = 6'h01;
  localparam int MSIX_TS_LSB = 16;
  localparam int MSIX_TS_W = 11;
  localparam logic [11:0] MSIX_TS_BIAS = 12'h001;
  localparam int BIR_LSB = 0;
  localparam int BIR_W = 3;
  localparam logic [2:0] BIR_MAX = 3'h5;
  localparam int LOC_OFS_LSB = 3;
  localparam logic [2:0] ALIGN_ZERO = 3'h0;
  localparam logic [7:0] CFG_BAR0_OFS = 8'h10;
  localparam int RB_SIZE_LSB = 24;
  localparam int RB_SIZE_W = 5;
  localparam logic [5:0] RB_SIZE_BIAS = 6'h14;
  localparam int RB_SUP_LSB = 4;
  localparam int RB_SUP_W = 20;
  localparam int RB_IDX_LSB = 0;
  localparam int RB_IDX_W = 3;
  // reset values and writable bits, highest index first
  localparam logic [NREG-1:0][31:0] REG_RST = {
    32'h0000_0004, 32'h0000_0003, 32'h0000_0002, 32'h0000_0001, 32'h0000_00f0,
    32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_7000, 32'h0000_6000, 32'h001f_0000, 32'h0000_0052};
  localparam logic [NREG-1:0][31:0] REG_MASK = {
    32'h1fff_fff7, 32'h1fff_fff7, 32'h1fff_fff7, 32'h1fff_fff7, 32'h1fff_fff7,
    32'h0000_0001, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001,
    32'hffff_ffff, 32'hffff_ffff, 32'h07ff_0001, 32'h0000_0073};

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfc_req_t;

  typedef struct packed {
    logic hit;
    logic [1:0] fn;
    logic [3:0] idx;
  } pfc_dec_t;

  typedef struct packed {
    logic [5:0] size_log2;
    logic [19:0] supported;
    logic [7:0] cfg_ofs;
  } pfc_rbar_t;

  typedef struct packed {
    logic msi_present;
    logic [5:0] msi_vec_count;
    logic msi_mask_cap;
    logic msix_present;
    logic [11:0] msix_vec_count;
    logic [7:0] msix_tbl_cfg_ofs;
    logic [31:0] msix_tbl_boff;
    logic [7:0] msix_pba_cfg_ofs;
    logic [31:0] msix_pba_boff;
    logic dsn_present;
    logic [63:0] dsn_serial;
    logic rbar_present;
    pfc_rbar_t [NRBAR-1:0] rbar;
  } pfc_cap_t;
endpackage : pfc_pkg

// file: hw/pfc_config_bank.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - msi vector field 0..5 means 1..32 vectors; 6 and 7 reserved
// - msi per-vector mask capable bit, resets to one
// - msi disable bit set hides the msi structure
// - msi-x vector count is table size field plus one
// - msi-x disable bit set hides the msi-x structure
// - msi-x table byte offset is offset field with three zero bits
// - table bar indicator 0..5 selects bar at 0x10..0x24
// - pending array byte offset is offset field with three zero bits
// - pending array bar indicator uses the same bar encoding
// - serial number structure present only while enable is one
// - writable 64-bit serial number, resets to zero, reported
// - resizable bar structure present only while enable set, resets one
// - entry default size is two to the field plus twenty bytes
// - supported mask bit i means size two to i plus twenty
// - entry bar index 0..5 names bar 0x10..0x24, lower dword
// - the bank is replicated for functions one to three
module pfc_config_bank (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire pfc_pkg::pfc_req_t bus_req,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  output pfc_pkg::pfc_cap_t [2:0] fn_cap
);

  logic [2:0][pfc_pkg::NREG-1:0][31:0] word_reg;
  logic [31:0] rdata_reg;
  logic rvalid_reg;
  pfc_pkg::pfc_cap_t [2:0] cap_reg;
  pfc_pkg::pfc_dec_t dec;

  //////////////////////////////////////////////////////////////////////////////
  function automatic pfc_pkg::pfc_dec_t pfc_decode(input logic [16:0] a);
    pfc_pkg::pfc_dec_t d;
    logic [4:0] page;
    d = '0;
    page = a[16:pfc_pkg::PAGE_LSB];
    d.hit = 1'b1;
    case (a[11:0])
      pfc_pkg::OFS_MSI: d.idx = pfc_pkg::IDX_MSI;
      pfc_pkg::OFS_MSIX: d.idx = pfc_pkg::IDX_MSIX;
      pfc_pkg::OFS_TBL: d.idx = pfc_pkg::IDX_TBL;
      pfc_pkg::OFS_PBA: d.idx = pfc_pkg::IDX_PBA;
      pfc_pkg::OFS_SN_EN: d.idx = pfc_pkg::IDX_SN_EN;
      pfc_pkg::OFS_SN_LO: d.idx = pfc_pkg::IDX_SN_LO;
      pfc_pkg::OFS_SN_HI: d.idx = pfc_pkg::IDX_SN_HI;
      pfc_pkg::OFS_RB_EN: d.idx = pfc_pkg::IDX_RB_EN;
      pfc_pkg::OFS_RB0: d.idx = pfc_pkg::IDX_RB0;
      pfc_pkg::OFS_RB1: d.idx = 4'(pfc_pkg::IDX_RB0 + 4'h1);
      pfc_pkg::OFS_RB2: d.idx = 4'(pfc_pkg::IDX_RB0 + 4'h2);
      pfc_pkg::OFS_RB3: d.idx = 4'(pfc_pkg::IDX_RB0 + 4'h3);
      pfc_pkg::OFS_RB4: d.idx = 4'(pfc_pkg::IDX_RB0 + 4'h4);
      default: d.hit = 1'b0;
    endcase
    if (page < pfc_pkg::FN1_BASE[16:12] || page > pfc_pkg::FN3_BASE[16:12]) begin
      d.hit = 1'b0;
    end
    d.fn = 2'(page - pfc_pkg::FN1_BASE[16:12]);
    return d;
  endfunction : pfc_decode

  // reserved bar selections map to offset zero so no bar is claimed
  function automatic logic [7:0] pfc_bar_ofs(input logic [2:0] bir);
    return (bir > pfc_pkg::BIR_MAX) ? 8'h00 : 8'(pfc_pkg::CFG_BAR0_OFS + {3'h0, bir, 2'h0});
  endfunction : pfc_bar_ofs

  function automatic pfc_pkg::pfc_cap_t pfc_derive(input logic [pfc_pkg::NREG-1:0][31:0] w);
    pfc_pkg::pfc_cap_t c;
    logic [2:0] mult;
    logic [31:0] rb;
    c = '0;
    rb = '0;
    mult = w[pfc_pkg::IDX_MSI][pfc_pkg::MSI_MULT_LSB +: pfc_pkg::MSI_MULT_W];
    c.msi_present = ~w[pfc_pkg::IDX_MSI][pfc_pkg::DIS_BIT];
    c.msi_vec_count = (mult > pfc_pkg::MSI_MULT_MAX) ? 6'h00 : (pfc_pkg::MSI_ONE_VEC << mult);
    c.msi_mask_cap = w[pfc_pkg::IDX_MSI][pfc_pkg::MSI_MASK_BIT];
    c.msix_present = ~w[pfc_pkg::IDX_MSIX][pfc_pkg::DIS_BIT];
    c.msix_vec_count = {1'b0, w[pfc_pkg::IDX_MSIX][pfc_pkg::MSIX_TS_LSB +: pfc_pkg::MSIX_TS_W]}
      + pfc_pkg::MSIX_TS_BIAS;
    c.msix_tbl_cfg_ofs = pfc_bar_ofs(w[pfc_pkg::IDX_TBL][pfc_pkg::BIR_LSB +: pfc_pkg::BIR_W]);
    c.msix_tbl_boff = {w[pfc_pkg::IDX_TBL][31:pfc_pkg::LOC_OFS_LSB], pfc_pkg::ALIGN_ZERO};
    c.msix_pba_cfg_ofs = pfc_bar_ofs(w[pfc_pkg::IDX_PBA][pfc_pkg::BIR_LSB +: pfc_pkg::BIR_W]);
    c.msix_pba_boff = {w[pfc_pkg::IDX_PBA][31:pfc_pkg::LOC_OFS_LSB], pfc_pkg::ALIGN_ZERO};
    c.dsn_present = w[pfc_pkg::IDX_SN_EN][pfc_pkg::EN_BIT];
    c.dsn_serial = {w[pfc_pkg::IDX_SN_HI], w[pfc_pkg::IDX_SN_LO]};
    c.rbar_present = w[pfc_pkg::IDX_RB_EN][pfc_pkg::EN_BIT];
    for (int e = 0; e < pfc_pkg::NRBAR; e++) begin
      rb = w[pfc_pkg::IDX_RB0 + e];
      // size exponent; the sizes software programs are taken as given
      c.rbar[e].size_log2 = {1'b0, rb[pfc_pkg::RB_SIZE_LSB +: pfc_pkg::RB_SIZE_W]}
        + pfc_pkg::RB_SIZE_BIAS;
      c.rbar[e].supported = rb[pfc_pkg::RB_SUP_LSB +: pfc_pkg::RB_SUP_W];
      c.rbar[e].cfg_ofs = pfc_bar_ofs(rb[pfc_pkg::RB_IDX_LSB +: pfc_pkg::RB_IDX_W]);
    end
    return c;
  endfunction : pfc_derive

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dec = pfc_decode(bus_req.addr);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int f = 0; f < pfc_pkg::NFN; f++) begin
        word_reg[f] <= pfc_pkg::REG_RST;
      end
    end else if (bus_req.valid && bus_req.write && dec.hit) begin
      word_reg[dec.fn][dec.idx] <= bus_req.wdata & pfc_pkg::REG_MASK[dec.idx];
    end
  end

  // unmapped reads answer zero; reserved bits are zero in storage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      rvalid_reg <= bus_req.valid && !bus_req.write;
      rdata_reg <= (bus_req.valid && !bus_req.write && dec.hit) ? word_reg[dec.fn][dec.idx] : '0;
    end
  end

  // advertised values are retimed so the core sees only flop outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= '0;
    end else begin
      for (int f = 0; f < pfc_pkg::NFN; f++) begin
        cap_reg[f] <= pfc_derive(word_reg[f]);
      end
    end
  end

  assign bus_rdata = rdata_reg;
  assign bus_rvalid = rvalid_reg;
  assign fn_cap = cap_reg;

  //////////////////////////////////////////////////////////////////////////////
  pfc_pkg::pfc_dec_t dec_d1, dec_d2;
  logic [31:0] wd_d2, wd_d1;
  logic wr_d1, wr_d2;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dec_d1 <= '0;
      dec_d2 <= '0;
      wd_d1 <= '0;
      wd_d2 <= '0;
      wr_d1 <= 1'b0;
      wr_d2 <= 1'b0;
    end else begin
      dec_d1 <= dec;
      dec_d2 <= dec_d1;
      wd_d1 <= bus_req.wdata;
      wd_d2 <= wd_d1;
      wr_d1 <= bus_req.valid && bus_req.write;
      wr_d2 <= wr_d1;
    end
  end

  chk_resv_read_zero:
    assert property (@(posedge ref_clk) disable iff (!resetn)
      rvalid_reg && dec_d1.hit |-> (rdata_reg & ~pfc_pkg::REG_MASK[dec_d1.idx]) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  chk_write_readback:
    assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_d2 && dec_d2.hit && rvalid_reg && dec_d1 == dec_d2
      |-> rdata_reg == (wd_d2 & pfc_pkg::REG_MASK[dec_d2.idx]))
    else $error("read back differs from write");

  chk_unmapped_zero:
    assert property (@(posedge ref_clk) disable iff (!resetn)
      rvalid_reg && !dec_d1.hit |-> rdata_reg == 32'h0000_0000)
    else $error("unmapped read nonzero");

  chk_rdata_idle:
    assert property (@(posedge ref_clk) disable iff (!resetn)
      !rvalid_reg |-> rdata_reg == 32'h0000_0000)
    else $error("read data not zero without a read");

  cov_msi_hidden: cover property (@(posedge ref_clk) disable iff (!resetn)
    !cap_reg[0].msi_present);
  cov_dsn_shown: cover property (@(posedge ref_clk) disable iff (!resetn)
    cap_reg[2].dsn_present);
  cov_readback: cover property (@(posedge ref_clk) disable iff (!resetn)
    wr_d2 && rvalid_reg && dec_d1 == dec_d2 && dec_d1.hit);
  cov_msix_hidden: cover property (@(posedge ref_clk) disable iff (!resetn)
    !cap_reg[2].msix_present);

  for (genvar g = 0; g < pfc_pkg::NFN; g++) begin : g_chk
    logic [pfc_pkg::NREG-1:0] w2;
    always_comb begin
      for (int i = 0; i < pfc_pkg::NREG; i++) begin
        w2[i] = wr_d2 && dec_d2.hit && dec_d2.fn == 2'(g) && dec_d2.idx == 4'(i);
      end
    end

    chk_msi_count:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_MSI] |-> cap_reg[g].msi_vec_count ==
        ((wd_d2[6:4] > 3'h5) ? 6'h00 : (6'h01 << wd_d2[6:4])))
      else $error("msi vector count wrong");
    chk_msi_mask:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_MSI] |-> cap_reg[g].msi_mask_cap == wd_d2[1])
      else $error("msi mask capability wrong");
    chk_msi_omit:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_MSI] |-> cap_reg[g].msi_present == !wd_d2[0])
      else $error("msi presence wrong");
    chk_msix_count:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_MSIX] |-> cap_reg[g].msix_vec_count == {1'b0, wd_d2[26:16]} + 12'h001)
      else $error("msi-x vector count wrong");
    chk_msix_omit:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_MSIX] |-> cap_reg[g].msix_present == !wd_d2[0])
      else $error("msi-x presence wrong");
    chk_tbl_offset:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_TBL] |-> cap_reg[g].msix_tbl_boff == {wd_d2[31:3], 3'h0})
      else $error("table byte offset wrong");
    chk_tbl_bar:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_TBL] && wd_d2[2:0] == 3'h5 |-> cap_reg[g].msix_tbl_cfg_ofs == 8'h24)
      else $error("table bar offset wrong");
    chk_pba_offset:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_PBA] |-> cap_reg[g].msix_pba_boff == {wd_d2[31:3], 3'h0})
      else $error("pba byte offset wrong");
    chk_pba_bar:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_PBA] |-> cap_reg[g].msix_pba_cfg_ofs ==
        ((wd_d2[2:0] > 3'h5) ? 8'h00 : 8'h10 + {3'h0, wd_d2[2:0], 2'h0}))
      else $error("pba bar offset wrong");
    chk_dsn_present:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_SN_EN] |-> cap_reg[g].dsn_present == wd_d2[0])
      else $error("serial number presence wrong");
    chk_dsn_serial:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_SN_HI] |-> cap_reg[g].dsn_serial[63:32] == wd_d2)
      else $error("serial number high word wrong");
    chk_dsn_low:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_SN_LO] |-> cap_reg[g].dsn_serial[31:0] == wd_d2)
      else $error("serial number low word wrong");
    chk_rbar_enable:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_RB_EN] |-> cap_reg[g].rbar_present == wd_d2[0])
      else $error("rbar presence wrong");
    chk_rbar_size:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_RB0] |-> cap_reg[g].rbar[0].size_log2 == {1'b0, wd_d2[28:24]} + 6'h14)
      else $error("rbar size exponent wrong");
    chk_rbar_supported:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_RB0] |-> cap_reg[g].rbar[0].supported == wd_d2[23:4])
      else $error("rbar supported mask wrong");
    chk_rbar_index:
      assert property (@(posedge ref_clk) disable iff (!resetn)
        w2[pfc_pkg::IDX_RB0] && wd_d2[2:0] > 3'h5 |-> cap_reg[g].rbar[0].cfg_ofs == 8'h00)
      else $error("rbar reserved index not rejected");
  end

endmodule : pfc_config_bank
`default_nettype wire

// file: testbench/pcie_fn_capability_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_fn_capability_config_tb;
  logic ref_clk;
  logic resetn;
  pfc_pkg::pfc_req_t bus_req;
  logic [31:0] bus_rdata;
  logic bus_rvalid;
  pfc_pkg::pfc_cap_t [2:0] fn_cap;
  logic [31:0] mdl [3][13];
  logic [31:0] r;
  logic [2:0] v3;
  int bad_count;
  int check_count;
  localparam logic [11:0] OFS [13] = '{pfc_pkg::OFS_MSI, pfc_pkg::OFS_MSIX, pfc_pkg::OFS_TBL,
    pfc_pkg::OFS_PBA, pfc_pkg::OFS_SN_EN, pfc_pkg::OFS_SN_LO, pfc_pkg::OFS_SN_HI,
    pfc_pkg::OFS_RB_EN, pfc_pkg::OFS_RB0, pfc_pkg::OFS_RB1, pfc_pkg::OFS_RB2,
    pfc_pkg::OFS_RB3, pfc_pkg::OFS_RB4};
  // holes: other page, unlisted offset, unaligned, page past function 3
  localparam logic [16:0] HOLES [5] = '{17'h0_40e8, 17'h0_50ec, 17'h0_50e9, 17'h0_80e8,
    17'h0_613c};

  pfc_config_bank DUT (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid),
    .fn_cap(fn_cap)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] addr_of(int f, int i);
    return pfc_pkg::FN1_BASE + 17'(f) * 17'h0_1000 + {5'h00, OFS[i]};
  endfunction : addr_of

  // reserved selector codes map to no bar
  function automatic logic [7:0] bar_ofs(logic [2:0] sel);
    return (sel <= 3'h5) ? 8'h10 + {3'h0, sel, 2'h0} : 8'h00;
  endfunction : bar_ofs

  function automatic pfc_pkg::pfc_cap_t cap_of(int f);
    pfc_pkg::pfc_cap_t c;
    c.msi_present = ~mdl[f][0][0];
    c.msi_vec_count = (mdl[f][0][6:4] <= 3'h5) ? 6'h01 << mdl[f][0][6:4] : 6'h00;
    c.msi_mask_cap = mdl[f][0][1];
    c.msix_present = ~mdl[f][1][0];
    c.msix_vec_count = {1'b0, mdl[f][1][26:16]} + 12'h001;
    c.msix_tbl_cfg_ofs = bar_ofs(mdl[f][2][2:0]);
    c.msix_tbl_boff = {mdl[f][2][31:3], 3'h0};
    c.msix_pba_cfg_ofs = bar_ofs(mdl[f][3][2:0]);
    c.msix_pba_boff = {mdl[f][3][31:3], 3'h0};
    c.dsn_present = mdl[f][4][0];
    c.dsn_serial = {mdl[f][6], mdl[f][5]};
    c.rbar_present = mdl[f][7][0];
    for (int i = 0; i < 5; i++) begin
      c.rbar[i].size_log2 = {1'b0, mdl[f][8+i][28:24]} + 6'h14;
      c.rbar[i].supported = mdl[f][8+i][23:4];
      c.rbar[i].cfg_ofs = bar_ofs(mdl[f][8+i][2:0]);
    end
    return c;
  endfunction : cap_of

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_bit(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_word(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_cap(string what, pfc_pkg::pfc_cap_t exp, pfc_pkg::pfc_cap_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_cap

  task automatic end_of_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // one request per call; a read is answered in the very next cycle
  task automatic xfer(logic w, logic [16:0] a, logic [31:0] d, logic [31:0] e);
    bus_req = '{1'b1, w, a, d};
    @(posedge ref_clk);
    #1;
    if (!w) begin
      cmp_bit("read valid", 1'b1, bus_rvalid);
      cmp_word("read data", e, bus_rdata);
    end else begin
      cmp_bit("write valid", 1'b0, bus_rvalid);
    end
  endtask : xfer

  task automatic wr(int f, int i, logic [31:0] d);
    xfer(1'b1, addr_of(f, i), d, 32'h0000_0000);
    mdl[f][i] = d & pfc_pkg::REG_MASK[i];
  endtask : wr

  task automatic rd(int f, int i);
    xfer(1'b0, addr_of(f, i), 32'h0000_0000, mdl[f][i]);
  endtask : rd

  task automatic check_all();
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 13; i++) begin
        rd(f, i);
      end
      cmp_cap("capability view", cap_of(f), fn_cap[f]);
    end
  endtask : check_all

  task automatic do_reset();
    resetn = 1'b0;
    bus_req = '0;
    repeat (12) @(posedge ref_clk);
    #1;
    cmp_bit("valid in reset", 1'b0, bus_rvalid);
    for (int f = 0; f < 3; f++) begin
      cmp_cap("cap in reset", '0, fn_cap[f]);
    end
    resetn = 1'b1;
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 13; i++) begin
        mdl[f][i] = pfc_pkg::REG_RST[i];
      end
    end
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end

  initial begin
    bad_count = 0;
    check_count = 0;
    r = $urandom(34);
    do_reset();
    check_all();
    // every code of each three-bit selector, reserved ones included
    for (int v = 0; v < 8; v++) begin
      v3 = 3'(v);
      r = $urandom();
      wr(1, 0, {r[31:7], v3, r[3:0]});
      wr(1, 2, {r[31:3], v3});
      wr(1, 3, {~r[31:3], ~v3});
      // entry zero also meets a reserved code
      wr(1, 8 + (v + 4) % 5, {r[31:3], v3});
      rd(1, 0);
      cmp_cap("selector decode", cap_of(1), fn_cap[1]);
    end
    // field extremes: widest table, largest legal and oversized bar sizes
    wr(2, 1, 32'hffff_ffff);
    // largest size with its supported bit set
    wr(2, 8, 32'h1380_0001);
    wr(2, 9, 32'hffff_ffff);
    wr(2, 6, 32'hffff_ffff);
    wr(2, 4, 32'h0000_0001);
    wr(2, 7, 32'h0000_0000);
    check_all();
    // back-to-back write and read, random function and word
    repeat (200) begin
      r = $urandom();
      wr(r[9:8] % 3, r[7:4] % 13, $urandom());
      rd(r[9:8] % 3, r[7:4] % 13);
      cmp_cap("random view", cap_of(r[9:8] % 3), fn_cap[r[9:8] % 3]);
    end
    // holes in the map take no writes and read as zero
    foreach (HOLES[k]) begin
      xfer(1'b1, HOLES[k], 32'hffff_ffff, 32'h0000_0000);
      xfer(1'b0, HOLES[k], 32'h0000_0000, 32'h0000_0000);
    end
    check_all();
    // reset in mid-run brings every word back
    do_reset();
    check_all();
    end_of_test();
  end
endmodule : pcie_fn_capability_config_tb
`default_nettype wire
